/* File: test/hcr_board.sv */
// Board model driving the attach pin and the strap.
`timescale 1ns/100ps
module hcr_board (
  // Hub status
  input wire logic standby,
  // Scenario requests
  input wire logic want,
  input wire logic [1:0] sel_in,
  // Board pins
  output logic attach,
  output logic [1:0] sel_out
);
  // The pin stays low while the hub is in standby.
  assign attach = want && !standby;
  // The strap matches the applied clock.
  assign sel_out = sel_in;
endmodule : hcr_board

/* File: test/hcr_ctrl_chk.sv */
// Checker for the start-up control.
`timescale 1ns/100ps
module hcr_ctrl_chk
  import hcr_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // Board and software inputs
  input wire logic ATTACH_REQUEST,
  input wire logic [hcr_pkg::REF_SEL_W-1:0] REF_SEL,
  input wire logic ATTACH_HOLD,
  // Status outputs
  input wire logic STANDBY,
  input wire logic INIT_STAGE,
  input wire logic COMM_STAGE,
  input wire logic [hcr_pkg::REF_SEL_W-1:0] REF_SEL_LATCHED,
  input wire logic [15:0] REF_FREQ_KHZ
);
  import hcr_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  logic wt;
  assign wt = INIT_STAGE && REF_FREQ_KHZ != 16'h0;
  a_reset_standby: assert property (disable iff (1'b0) !RST_B |-> STANDBY && !COMM_STAGE)
    else $error("reset");
  a_freq_decode: assert property (REF_FREQ_KHZ != 16'h0 |-> REF_FREQ_KHZ ==
    (REF_SEL_LATCHED == 2'h0 ? 16'h9600 : REF_SEL_LATCHED == 2'h1 ? 16'h6590 :
    REF_SEL_LATCHED == 2'h2 ? 16'h4b00 : 16'h2ee0)) else $error("freq");
  a_strap_kept: assert property ($past(REF_FREQ_KHZ) != 16'h0 |-> $stable(REF_SEL_LATCHED))
    else $error("strap");
  a_comm_stays: assert property (COMM_STAGE |=> COMM_STAGE) else $error("comm");
  a_hold_release: assert property (wt && !ATTACH_HOLD |=> COMM_STAGE) else $error("hold");
  a_hold_blocks: assert property ((!COMM_STAGE && ATTACH_HOLD && !ATTACH_REQUEST)[*4]
    |=> !COMM_STAGE) else $error("block");
  a_strap_high: assert property (ATTACH_REQUEST[*4] ##0 $rose(REF_FREQ_KHZ != 16'h0)
    |-> COMM_STAGE) else $error("auto");
  a_edge_enter: assert property ($rose(ATTACH_REQUEST) && wt ##1 ATTACH_REQUEST[*3]
    |-> ##[0:2] COMM_STAGE) else $error("edge");
  a_sync_delay: assert property ($rose(ATTACH_REQUEST) && ATTACH_HOLD && !COMM_STAGE
    |=> !COMM_STAGE) else $error("sync");
  c_hold: cover property ($rose(COMM_STAGE) && !ATTACH_HOLD);
  c_high: cover property ($rose(COMM_STAGE) && ATTACH_HOLD);
  c_edge: cover property ($rose(ATTACH_REQUEST) && wt);
endmodule : hcr_ctrl_chk
bind hcr_ctrl hcr_ctrl_chk u_chk (.CLOCK(CLOCK), .RST_B(RST_B), .ATTACH_REQUEST(ATTACH_REQUEST),
  .REF_SEL(REF_SEL), .ATTACH_HOLD(ATTACH_HOLD), .STANDBY(STANDBY), .INIT_STAGE(INIT_STAGE),
  .COMM_STAGE(COMM_STAGE), .REF_SEL_LATCHED(REF_SEL_LATCHED), .REF_FREQ_KHZ(REF_FREQ_KHZ));

/* File: test/test_hub_connect_reference_clock_input_select.sv */
// Bench for the start-up control.
`timescale 1ns/100ps
module test_hub_connect_reference_clock_input_select;
  logic clk = 1'b0, rst_b = 1'b1, want = 1'b0, hold = 1'b1;
  logic att, stb, ini, comm;
  logic [1:0] sel = 2'h0, rsel, lat;
  logic [15:0] khz;
  int fails = 0, num_checks = 0;
  logic [31:0] rnd = 32'h034348b2;
  hcr_board PB (.standby(stb), .want(want), .sel_in(sel), .attach(att), .sel_out(rsel));
  hcr_ctrl DUT (.CLOCK(clk), .RST_B(rst_b), .ATTACH_REQUEST(att), .REF_SEL(rsel),
    .ATTACH_HOLD(hold), .STANDBY(stb), .INIT_STAGE(ini), .COMM_STAGE(comm),
    .REF_SEL_LATCHED(lat), .REF_FREQ_KHZ(khz));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  function automatic logic [15:0] f(input logic [1:0] s);
    return s == 2'h0 ? 16'h9600 : s == 2'h1 ? 16'h6590 : s == 2'h2 ? 16'h4b00 : 16'h2ee0;
  endfunction : f
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] v);
    num_checks++;
    if (v !== e)
    begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, v);
    end
  endtask : chk
  task automatic conclude;
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  initial forever #2 clk = ~clk;
  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    conclude;
  end
  // Mode 0 strapped high, 1 hold release, 2 pin edge; every strap code in each.
  initial
  begin
    for (int i = 0; i < 12; i++)
    begin
      rnd = xs(rnd);
      rst_b <= 1'b0;
      want <= i % 3 == 0;
      hold <= 1'b1;
      sel <= 2'(i / 3);
      repeat (12) @(posedge clk);
      chk("standby", 16'h0001, stb);
      chk("init_in_reset", 16'h0000, ini);
      rst_b <= 1'b1;
      repeat (10 + rnd[3:0]) @(posedge clk);
      #1;
      chk("freq", f(2'(i / 3)), khz);
      chk("auto", 16'(i % 3 == 0), comm);
      chk("init", 16'(i % 3 != 0), ini);
      chk("standby_off", 16'h0000, stb);
      @(posedge clk);
      if (i % 3 == 1)
        hold <= 1'b0;
      else
        want <= 1'b1;
      sel <= rnd[9:8];
      repeat (6) @(posedge clk);
      #1;
      chk("entered", 16'h0001, comm);
      chk("init_done", 16'h0000, ini);
      chk("kept", 16'(i / 3), lat);
      @(posedge clk);
    end
    conclude;
  end
endmodule : test_hub_connect_reference_clock_input_select

/* File: verilog/hcr_ctrl.sv */
// Start-up control: attach request handling and reference select capture.
//
// Function
// - Enter communication stage when attach pin high
// - Pin low: wait for software hold release
// - Pin high: enter automatically, ignore hold bit
// - Rising attach edge enters communication stage
// - Rising clock edges only, duty cycle irrelevant
// - Decode strap: 38.4, 26.0, 19.2, 12.0 MHz
// - Capture strap once during initialisation
// - Reset clears logic and holds standby
`timescale 1ns/100ps
module hcr_ctrl
  import hcr_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // Board pins
  input wire logic ATTACH_REQUEST,
  input wire logic [hcr_pkg::REF_SEL_W-1:0] REF_SEL,
  // Software hold bit from the port interlock register, high holds the hub
  input wire logic ATTACH_HOLD,
  // Status
  output logic STANDBY,
  output logic INIT_STAGE,
  output logic COMM_STAGE,
  output logic [hcr_pkg::REF_SEL_W-1:0] REF_SEL_LATCHED,
  output logic [15:0] REF_FREQ_KHZ
);
  import hcr_pkg::*;

  logic attach_sync;
  logic [REF_SEL_W-1:0] ref_sel_sync;
  logic attach_prev;
  logic next_attach_prev;
  logic attach_rise;
  logic capture;
  hcr_stage_t stage;
  hcr_stage_t next_stage;
  logic [3:0] init_cnt;
  logic [3:0] next_init_cnt;
  logic [REF_SEL_W-1:0] next_ref_sel;
  logic [15:0] next_freq;
  logic next_standby;

  // Pins come from the board, so both pass two flops first.
  hcr_sync #(.WIDTH(1)) u_sync_attach
  (
    .clk(CLOCK),
    .rst_b(RST_B),
    .async_in(ATTACH_REQUEST),
    .sync_out(attach_sync)
  );

  hcr_sync #(.WIDTH(REF_SEL_W)) u_sync_sel
  (
    .clk(CLOCK),
    .rst_b(RST_B),
    .async_in(REF_SEL),
    .sync_out(ref_sel_sync)
  );

  // Edge detection looks only at synchronised samples.
  // The previous sample resets low, the level the pin keeps in standby, so a pin
  // strapped high shows its first edge inside initialisation, where it is not used.
  always_comb
  begin
    next_attach_prev = attach_sync;
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      attach_prev <= ATTACH_PREV_RST;
    end
    else
    begin
      attach_prev <= next_attach_prev;
    end
  end

  assign attach_rise = attach_sync & ~attach_prev;

  // Taking the strap on the last initialisation cycle lets both synchronisers
  // fill after reset, at the cost of a few cycles of start-up.
  assign capture = (stage == HCR_INIT) && (init_cnt == INIT_CYCLES);

  // Initialisation counter, frozen once it reaches its end value.
  always_comb
  begin
    next_init_cnt = init_cnt;
    if ((stage == HCR_INIT) && (init_cnt != INIT_CYCLES))
    begin
      next_init_cnt = init_cnt + 4'h1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      init_cnt <= INIT_CNT_RST;
    end
    else
    begin
      init_cnt <= next_init_cnt;
    end
  end

  // Stage sequencing.
  always_comb
  begin
    next_stage = stage;
    unique case (stage)
      HCR_INIT:
      begin
        if (capture)
        begin
          // A pin already high means it is strapped high; go straight on.
          if (attach_sync)
          begin
            next_stage = HCR_COMM;
          end
          else
          begin
            next_stage = HCR_WAIT;
          end
        end
      end
      HCR_WAIT:
      begin
        // A rising edge means the pin is driven, not tied low.
        if (attach_rise)
        begin
          next_stage = HCR_COMM;
        end
        else if (!ATTACH_HOLD)
        begin
          next_stage = HCR_COMM;
        end
      end
      HCR_COMM:
      begin
        // Communication stage is left only through reset.
        next_stage = HCR_COMM;
      end
      default:
      begin
        next_stage = HCR_INIT;
      end
    endcase
  end

  // Rising edges only; no logic uses the falling edge, so duty cycle is moot.
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      stage <= HCR_INIT;
    end
    else
    begin
      stage <= next_stage;
    end
  end

  // Strap capture and decode.
  always_comb
  begin
    next_ref_sel = REF_SEL_LATCHED;
    next_freq = REF_FREQ_KHZ;
    if (capture)
    begin
      // The strap is taken once here and frozen until the next reset.
      next_ref_sel = ref_sel_sync;
      unique case (ref_sel_sync)
        REF_SEL_38M4: next_freq = FREQ_KHZ_38M4;
        REF_SEL_26M0: next_freq = FREQ_KHZ_26M0;
        REF_SEL_19M2: next_freq = FREQ_KHZ_19M2;
        REF_SEL_12M0: next_freq = FREQ_KHZ_12M0;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      REF_SEL_LATCHED <= REF_SEL_RST;
      REF_FREQ_KHZ <= FREQ_KHZ_RST;
    end
    else
    begin
      REF_SEL_LATCHED <= next_ref_sel;
      REF_FREQ_KHZ <= next_freq;
    end
  end

  // Standby drops on the first edge after reset, so it cannot fall while the
  // reference clock is stopped; a hub without a clock stays in standby.
  always_comb
  begin
    next_standby = 1'b0;
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      STANDBY <= STANDBY_RST;
    end
    else
    begin
      STANDBY <= next_standby;
    end
  end

  // Both stage flags decode registered state and settle right after each edge.
  assign INIT_STAGE = (stage != HCR_COMM) & ~STANDBY;
  assign COMM_STAGE = (stage == HCR_COMM);

endmodule : hcr_ctrl

/* File: verilog/hcr_pkg.sv */
// Constants and types for the hub attach and reference-select start-up control.
package hcr_pkg;

  // Width of the reference select strap.
  localparam int unsigned REF_SEL_W = 2;

  // Strap codes for the reference frequency.
  localparam logic [1:0] REF_SEL_38M4 = 2'h0;
  localparam logic [1:0] REF_SEL_26M0 = 2'h1;
  localparam logic [1:0] REF_SEL_19M2 = 2'h2;
  localparam logic [1:0] REF_SEL_12M0 = 2'h3;

  // Reference frequencies in kHz, for software or PLL setup downstream.
  localparam logic [15:0] FREQ_KHZ_38M4 = 16'h9600;
  localparam logic [15:0] FREQ_KHZ_26M0 = 16'h6590;
  localparam logic [15:0] FREQ_KHZ_19M2 = 16'h4b00;
  localparam logic [15:0] FREQ_KHZ_12M0 = 16'h2ee0;

  // Reset values.
  localparam logic [1:0] REF_SEL_RST = 2'h0;
  localparam logic [15:0] FREQ_KHZ_RST = 16'h0000;
  localparam logic [3:0] INIT_CNT_RST = 4'h0;
  localparam logic STANDBY_RST = 1'b1;
  localparam logic ATTACH_PREV_RST = 1'b0;

  // Cycles spent in initialisation before straps are taken.
  localparam logic [3:0] INIT_CYCLES = 4'h4;

  // Start-up stages.
  typedef enum logic [1:0]
  {
    HCR_INIT = 2'b00,
    HCR_WAIT = 2'b01,
    HCR_COMM = 2'b10
  } hcr_stage_t;

  // Attach usage option codes; no module in the project selects or stores one.
  typedef enum logic [1:0]
  {
    HCR_OPT_LOW  = 2'b00,
    HCR_OPT_HIGH = 2'b01,
    HCR_OPT_EDGE = 2'b10
  } hcr_opt_t;

endpackage : hcr_pkg

/* File: verilog/hcr_sync.sv */
// Two-stage synchroniser for asynchronous level inputs.
`timescale 1ns/100ps
module hcr_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second one.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : hcr_sync
